/* core/fss_core.sv */
// fss_core: sector/bank status register with array-select banking, program-data
// staging registers and a small write engine that hands words to the flash array.
// assumes the array answers each request with flash_done, optionally flash_fail.
//
// Functional notes
// - status register shows banks 3/2 when array_select is 0, banks 1/0 when 1
// - extension array: bits 1:0 set during erase for bank-3 sectors, cleared if clean
// - extension array: bits 9:8 report banks 3/2 during erase, cleared if clean
// - primary array: bits 1:0 set during erase for bank-1 sectors, cleared if clean
// - primary array: bits 9:8 report banks 1/0 during erase, cleared if clean
// - with error flag set, a status bit of 1 means erase error there
// - error clear and hold set: status 1 means erase suspended; else meaningless
// - address and data staging registers stay fixed during a program operation
// - double write puts data0 at even word address, data1 at next odd word
// - error flag set on write failure or bad setup, held until software clears
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module fss_core
    import fss_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    input wire logic pclk, // apb clock, 40 MHz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic flash_req, // one-cycle request to program one word
    output logic flash_erase, // one-cycle request to erase selected sectors
    output logic [20:0] flash_addr, // word byte address to the array
    output logic [31:0] flash_wdata, // data word to the array
    output logic [3:0] erase_sectors, // sectors chosen for erase, array_select applied
    input wire logic flash_done, // array finished current word or erase
    input wire logic flash_fail, // array reports failure with flash_done
    input wire logic [3:0] fail_where, // failing {bank_hi, bank_lo, sec1, sec0}
    output logic write_busy // engine active
);

    typedef struct packed {
        fss_state_t st;
        logic array_select;
        logic hold_request;
        logic single_word_write_select;
        logic double_word_write_select;
        logic erase_select;
        logic [3:0] ext_status;
        logic [3:0] pri_status;
        logic [15:0] data0_lo;
        logic [15:0] data0_hi;
        logic [15:0] data1_lo;
        logic [15:0] data1_hi;
        logic [15:0] addr_lo;
        logic [15:0] addr_hi;
        logic err_flag;
        logic err_erase;
        logic err_prog;
        logic err_seq;
        logic req;
        logic erase_go;
        logic [20:0] out_addr;
        logic [31:0] out_data;
        logic [31:0] rdata;
        logic slverr;
        logic rdy;
    } fss_regs_t;

    fss_regs_t r_q;
    fss_regs_t r_d;

    // ==========================================================================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] nv;
        nv = old;
        if (strb[0]) begin
            nv[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            nv[15:8] = wd[15:8];
        end
        return (nv & mask) | (old & ~mask);
    endfunction

    function automatic logic [15:0] status_view(input logic [3:0] s);
        logic [15:0] v;
        v = 16'h0000;
        v[FSS_SEC_LO +: 2] = s[1:0];
        v[FSS_BANK_LO +: 2] = s[3:2];
        return v;
    endfunction

    logic access;
    logic wr;
    logic [19:0] idx;
    logic busy;
    logic staging_lock;

    assign access = psel & penable;
    assign wr = access & pwrite;
    assign idx = 20'(paddr >> 2);
    assign busy = r_q.st != FSS_IDLE;
    assign staging_lock = busy;

    // ==========================================================================
    // next-state logic
    always_comb begin
        logic [15:0] ctl_w;
        logic [15:0] stat_w;
        logic [15:0] err_w;
        logic launch;
        logic bad_setup;
        logic [2:0] sel_cnt;
        logic hw_err;
        ctl_w = 16'h0000;
        stat_w = 16'h0000;
        err_w = 16'h0000;
        launch = 1'b0;
        bad_setup = 1'b0;
        sel_cnt = 3'b000;
        hw_err = 1'b0;
        r_d = r_q;
        r_d.req = 1'b0;
        r_d.erase_go = 1'b0;
        r_d.slverr = 1'b0;
        r_d.rdy = 1'b0;
        if (psel & ~penable) begin
            r_d.rdy = 1'b1;
        end
        // ---------------- reads
        r_d.rdata = 32'h0000_0000;
        if (psel & ~penable & ~pwrite) begin
            unique case (idx)
                FSS_IDX_SECTOR_STATUS_HIGH: r_d.rdata[15:0] = r_q.array_select ?
                    status_view(r_q.pri_status) : status_view(r_q.ext_status);
                FSS_IDX_PROGRAM_DATA0_LOW: r_d.rdata[15:0] = r_q.data0_lo;
                FSS_IDX_PROGRAM_DATA0_HIGH: r_d.rdata[15:0] = r_q.data0_hi;
                FSS_IDX_PROGRAM_DATA1_LOW: r_d.rdata[15:0] = r_q.data1_lo;
                FSS_IDX_PROGRAM_DATA1_HIGH: r_d.rdata[15:0] = r_q.data1_hi;
                FSS_IDX_TARGET_LOC_LOW: r_d.rdata[15:0] = r_q.addr_lo;
                FSS_IDX_TARGET_LOC_HIGH: r_d.rdata[15:0] = r_q.addr_hi;
                FSS_IDX_WRITE_ERROR: begin
                    r_d.rdata[FSS_ERR_FLAG] = r_q.err_flag;
                    r_d.rdata[FSS_ERR_ERASE] = r_q.err_erase;
                    r_d.rdata[FSS_ERR_PROG] = r_q.err_prog;
                    r_d.rdata[FSS_ERR_SEQ] = r_q.err_seq;
                end
                FSS_IDX_CONTROL: begin
                    r_d.rdata[FSS_CTL_LAUNCH] = busy;
                    r_d.rdata[FSS_CTL_SINGLE] = r_q.single_word_write_select;
                    r_d.rdata[FSS_CTL_DOUBLE] = r_q.double_word_write_select;
                    r_d.rdata[FSS_CTL_HOLD] = r_q.hold_request;
                    r_d.rdata[FSS_CTL_ERASE] = r_q.erase_select;
                    r_d.rdata[FSS_CTL_ARRAY] = r_q.array_select;
                    r_d.rdata[FSS_CTL_BUSY] = busy;
                end
                default: r_d.slverr = 1'b1;
            endcase
        end
        if (psel & ~penable & pwrite) begin
            unique case (idx)
                FSS_IDX_SECTOR_STATUS_HIGH, FSS_IDX_PROGRAM_DATA0_LOW, FSS_IDX_PROGRAM_DATA0_HIGH,
                FSS_IDX_PROGRAM_DATA1_LOW, FSS_IDX_PROGRAM_DATA1_HIGH, FSS_IDX_TARGET_LOC_LOW,
                FSS_IDX_TARGET_LOC_HIGH, FSS_IDX_WRITE_ERROR, FSS_IDX_CONTROL: r_d.slverr = 1'b0;
                default: r_d.slverr = 1'b1;
            endcase
        end
        // ---------------- writes (take effect at the access edge)
        if (wr) begin
            unique case (idx)
                FSS_IDX_SECTOR_STATUS_HIGH: begin
                    if (!busy) begin
                        stat_w = merge16(r_d.array_select ? status_view(r_q.pri_status) :
                            status_view(r_q.ext_status), pwdata, pstrb, FSS_MASK_STATUS);
                        if (r_q.array_select) begin
                            r_d.pri_status = {stat_w[FSS_BANK_LO +: 2], stat_w[FSS_SEC_LO +: 2]};
                        end else begin
                            r_d.ext_status = {stat_w[FSS_BANK_LO +: 2], stat_w[FSS_SEC_LO +: 2]};
                        end
                    end
                end
                FSS_IDX_PROGRAM_DATA0_LOW: if (!staging_lock) r_d.data0_lo = merge16(r_q.data0_lo,
                    pwdata, pstrb, 16'hffff);
                FSS_IDX_PROGRAM_DATA0_HIGH: if (!staging_lock) r_d.data0_hi = merge16(r_q.data0_hi,
                    pwdata, pstrb, 16'hffff);
                FSS_IDX_PROGRAM_DATA1_LOW: if (!staging_lock) r_d.data1_lo = merge16(r_q.data1_lo,
                    pwdata, pstrb, 16'hffff);
                FSS_IDX_PROGRAM_DATA1_HIGH: if (!staging_lock) r_d.data1_hi = merge16(r_q.data1_hi,
                    pwdata, pstrb, 16'hffff);
                FSS_IDX_TARGET_LOC_LOW: if (!staging_lock) r_d.addr_lo = merge16(r_q.addr_lo,
                    pwdata, pstrb, FSS_MASK_ADDR_LOW);
                FSS_IDX_TARGET_LOC_HIGH: if (!staging_lock) r_d.addr_hi = merge16(r_q.addr_hi,
                    pwdata, pstrb, FSS_MASK_ADDR_HIGH);
                FSS_IDX_WRITE_ERROR: begin
                    // write one to clear; hardware sets below win over this
                    err_w = merge16(16'h0000, pwdata, pstrb, FSS_MASK_ERR);
                    if (err_w[FSS_ERR_FLAG]) r_d.err_flag = 1'b0;
                    if (err_w[FSS_ERR_ERASE]) r_d.err_erase = 1'b0;
                    if (err_w[FSS_ERR_PROG]) r_d.err_prog = 1'b0;
                    if (err_w[FSS_ERR_SEQ]) r_d.err_seq = 1'b0;
                end
                FSS_IDX_CONTROL: begin
                    ctl_w = merge16(16'h0000, pwdata, pstrb, 16'hffff);
                    r_d.hold_request = ctl_w[FSS_CTL_HOLD];
                    if (!busy && r_q.st != FSS_HELD) begin
                        r_d.array_select = ctl_w[FSS_CTL_ARRAY];
                    end
                    if (ctl_w[FSS_CTL_LAUNCH]) begin
                        r_d.single_word_write_select = ctl_w[FSS_CTL_SINGLE];
                        r_d.double_word_write_select = ctl_w[FSS_CTL_DOUBLE];
                        r_d.erase_select = ctl_w[FSS_CTL_ERASE];
                        launch = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // ---------------- launch checks
        sel_cnt = 3'({2'b00, ctl_w[FSS_CTL_SINGLE]} + {2'b00, ctl_w[FSS_CTL_DOUBLE]}
            + {2'b00, ctl_w[FSS_CTL_ERASE]});
        if (launch) begin
            bad_setup = r_q.err_flag | (r_q.hold_request & (r_q.st != FSS_HELD)) | ctl_w[FSS_CTL_HOLD]
                | (sel_cnt != 3'd1) | (ctl_w[FSS_CTL_DOUBLE] & r_q.addr_lo[2]) | (busy && r_q.st != FSS_HELD);
        end
        // ---------------- engine
        unique case (r_q.st)
            FSS_IDLE: begin
                if (launch && !bad_setup) begin
                    r_d.out_addr = {r_q.addr_hi[4:0], r_q.addr_lo};
                    r_d.out_data = {r_q.data0_hi, r_q.data0_lo};
                    if (ctl_w[FSS_CTL_ERASE]) begin
                        r_d.erase_go = 1'b1;
                        r_d.st = FSS_ERASE;
                        if (r_d.array_select) begin
                            r_d.pri_status = r_q.pri_status | {2'b00, 2'b11};
                        end else begin
                            r_d.ext_status = r_q.ext_status | {2'b00, 2'b11};
                        end
                    end else begin
                        r_d.req = 1'b1;
                        r_d.st = FSS_PROG_EVEN;
                    end
                end
            end
            FSS_PROG_EVEN: begin
                if (flash_done) begin
                    if (flash_fail) begin
                        r_d.err_prog = 1'b1;
                        hw_err = 1'b1;
                        r_d.st = FSS_IDLE;
                    end else if (r_q.double_word_write_select) begin
                        r_d.out_addr = 21'(r_q.out_addr + 21'h4);
                        r_d.out_data = {r_q.data1_hi, r_q.data1_lo};
                        r_d.req = 1'b1;
                        r_d.st = FSS_PROG_ODD;
                    end else begin
                        r_d.st = FSS_IDLE;
                    end
                end
            end
            FSS_PROG_ODD: begin
                if (flash_done) begin
                    r_d.err_prog = r_d.err_prog | flash_fail;
                    hw_err = flash_fail;
                    r_d.st = FSS_IDLE;
                end
            end
            FSS_ERASE: begin
                if (r_q.hold_request) begin
                    r_d.st = FSS_HELD; // bits stay: erase suspended there
                end else if (flash_done) begin
                    r_d.st = FSS_IDLE;
                    if (flash_fail) begin
                        r_d.err_erase = 1'b1;
                        hw_err = 1'b1;
                        if (r_q.array_select) begin
                            r_d.pri_status = fail_where;
                        end else begin
                            r_d.ext_status = fail_where;
                        end
                    end else if (r_q.array_select) begin
                        r_d.pri_status = 4'h0;
                    end else begin
                        r_d.ext_status = 4'h0;
                    end
                end else if (r_q.array_select) begin
                    r_d.pri_status[3:2] = 2'b11;
                end else begin
                    r_d.ext_status[3:2] = 2'b11;
                end
            end
            FSS_HELD: begin
                if (launch && !bad_setup && ctl_w[FSS_CTL_ERASE]) begin
                    r_d.st = FSS_ERASE;
                    r_d.erase_go = 1'b1;
                end
            end
            default: r_d.st = FSS_IDLE;
        endcase
        if (launch && bad_setup) begin
            r_d.err_seq = 1'b1;
            hw_err = 1'b1;
        end
        if (hw_err) begin
            r_d.err_flag = 1'b1;
        end
        if (r_d.st == FSS_IDLE && r_q.st != FSS_IDLE) begin
            r_d.single_word_write_select = 1'b0;
            r_d.double_word_write_select = 1'b0;
            r_d.erase_select = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{st: FSS_IDLE, ext_status: FSS_RST_STATUS[3:0], pri_status: FSS_RST_STATUS[3:0],
                data0_lo: FSS_RST_DATA, data0_hi: FSS_RST_DATA, data1_lo: FSS_RST_DATA,
                data1_hi: FSS_RST_DATA, addr_lo: FSS_RST_ADDR, addr_hi: FSS_RST_ADDR,
                default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================================
    // outputs
    assign prdata = r_q.rdata;
    assign pready = r_q.rdy;
    assign pslverr = r_q.slverr & r_q.rdy;
    assign flash_req = r_q.req;
    assign flash_erase = r_q.erase_go;
    assign flash_addr = r_q.out_addr;
    assign flash_wdata = r_q.out_data;
    assign erase_sectors = r_q.array_select ? r_q.pri_status : r_q.ext_status;
    assign write_busy = busy;

endmodule // fss_core

/* core/fss_pkg.sv */
// fss_pkg: register map, field positions, reset values and engine states for the
// flash sector status and program-data staging block.
// assumes apb with 32-bit data, one register per aligned word.
package fss_pkg;

    // ==========================================================================
    // register indices (printed offsets are not word multiples: byte = 4 * index)
    localparam logic [19:0] FSS_IDX_SECTOR_STATUS_HIGH = 20'he0006;
    localparam logic [19:0] FSS_IDX_PROGRAM_DATA0_LOW = 20'he0008;
    localparam logic [19:0] FSS_IDX_PROGRAM_DATA0_HIGH = 20'he000a;
    localparam logic [19:0] FSS_IDX_PROGRAM_DATA1_LOW = 20'he000c;
    localparam logic [19:0] FSS_IDX_PROGRAM_DATA1_HIGH = 20'he000e;
    localparam logic [19:0] FSS_IDX_TARGET_LOC_LOW = 20'he0010;
    localparam logic [19:0] FSS_IDX_TARGET_LOC_HIGH = 20'he0012;
    localparam logic [19:0] FSS_IDX_WRITE_ERROR = 20'he0014;
    localparam logic [19:0] FSS_IDX_CONTROL = 20'he0016;

    // ==========================================================================
    // field positions
    localparam int FSS_SEC_LO = 0;
    localparam int FSS_BANK_LO = 8;
    localparam int FSS_CTL_LAUNCH = 0;
    localparam int FSS_CTL_SINGLE = 1;
    localparam int FSS_CTL_DOUBLE = 2;
    localparam int FSS_CTL_HOLD = 3;
    localparam int FSS_CTL_ERASE = 4;
    localparam int FSS_CTL_ARRAY = 5;
    localparam int FSS_CTL_BUSY = 8;
    localparam int FSS_ERR_FLAG = 0;
    localparam int FSS_ERR_ERASE = 1;
    localparam int FSS_ERR_PROG = 2;
    localparam int FSS_ERR_SEQ = 6;

    // ==========================================================================
    // reset values and writable masks
    localparam logic [15:0] FSS_RST_STATUS = 16'h0000;
    localparam logic [15:0] FSS_RST_DATA = 16'hffff;
    localparam logic [15:0] FSS_RST_ADDR = 16'h0000;
    localparam logic [15:0] FSS_MASK_STATUS = 16'h0303;
    localparam logic [15:0] FSS_MASK_ADDR_LOW = 16'hfffc;
    localparam logic [15:0] FSS_MASK_ADDR_HIGH = 16'h001f;
    localparam logic [15:0] FSS_MASK_ERR = 16'h0047;

    // ==========================================================================
    // engine timing
    localparam int FSS_WORD_CYCLES = 4;

    typedef enum logic [2:0] {
        FSS_IDLE = 3'b000,
        FSS_PROG_EVEN = 3'b001,
        FSS_PROG_ODD = 3'b010,
        FSS_ERASE = 3'b011,
        FSS_HELD = 3'b100
    } fss_state_t;

endpackage

/* testbench/fss_core_props.sv */
// fss_core_props: apb answer and flash-side timing assertions for fss_core.
// assumes it is bound to fss_core and sees only that module's ports.
`timescale 1ns/1ps

module fss_core_props
    import fss_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb strobes
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic flash_req, // program request
    input wire logic flash_erase, // erase request
    input wire logic [20:0] flash_addr, // word byte address to array
    input wire logic [31:0] flash_wdata, // word data to array
    input wire logic [3:0] erase_sectors, // erase choice
    input wire logic flash_done, // array done
    input wire logic flash_fail, // array failure
    input wire logic [3:0] fail_where, // failing locations
    input wire logic write_busy // engine active
);
    // ==========================================
    // address decode
    logic [ADDR_W-3:0] idx;
    logic mapped;
    assign idx = paddr[ADDR_W-1:2];
    assign mapped = idx >= FSS_IDX_SECTOR_STATUS_HIGH && idx <= FSS_IDX_CONTROL && !paddr[2];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // assertions
    setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr) else $error("unmapped not refused");
    mapped_ok_a: assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
    status_resv_a: assert property (pready && !pwrite && idx == FSS_IDX_SECTOR_STATUS_HIGH
        |-> prdata[15:10] == 6'h00 && prdata[7:2] == 6'h00) else $error("reserved status bit set");
    req_pulse_a: assert property (flash_req |=> !flash_req) else $error("program request too long");
    erase_pulse_a: assert property (flash_erase |=> !flash_erase) else $error("erase request too long");
    req_busy_a: assert property (flash_req || flash_erase |-> write_busy) else $error("request while idle");
    staged_stable_a: assert property (write_busy |=> flash_req ||
        ($stable(flash_addr) && $stable(flash_wdata))) else $error("staged word moved");

    cover property (flash_req);
    cover property (flash_erase);
    cover property (pslverr);
endmodule // fss_core_props

bind fss_core fss_core_props #(.ADDR_W(ADDR_W)) fss_core_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_req(flash_req), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .erase_sectors(erase_sectors),
    .flash_done(flash_done), .flash_fail(flash_fail), .fail_where(fail_where), .write_busy(write_busy));

/* testbench/fss_core_bench.sv */
// fss_core_bench: self-checking bench for the status and staging block.
// assumes fss_pkg, fss_core and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end

module fss_core_bench
    import fss_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic flash_req, flash_erase, flash_done, flash_fail, write_busy;
    logic [21:0] paddr;
    logic [31:0] pwdata, prdata, flash_wdata, rdata;
    logic [20:0] flash_addr;
    logic [3:0] erase_sectors, fail_where;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [19:0] t_idx [7] = '{FSS_IDX_PROGRAM_DATA0_LOW, FSS_IDX_PROGRAM_DATA0_HIGH, FSS_IDX_PROGRAM_DATA1_LOW,
        FSS_IDX_PROGRAM_DATA1_HIGH, FSS_IDX_TARGET_LOC_LOW, FSS_IDX_TARGET_LOC_HIGH, FSS_IDX_SECTOR_STATUS_HIGH};
    logic [15:0] t_wd [7] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] t_ex [7] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'hfffc, 16'h001f, 16'h0303};

    fss_core #(.ADDR_W(22)) fss_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_req(flash_req), .flash_erase(flash_erase), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .erase_sectors(erase_sectors), .flash_done(flash_done),
        .flash_fail(flash_fail), .fail_where(fail_where), .write_busy(write_busy));

    always #12.5 pclk = ~pclk;

    // ==========================================
    // tasks
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one apb transfer; answer taken at the edge where pready is high, then released
    task automatic apb(input logic wr, input logic [19:0] idx, input logic [15:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_reg(input logic [19:0] idx, input logic [15:0] ex);
        apb(1'b0, idx, 16'h0000);
        `CHK(rdata[15:0], ex)
    endtask

    // 0: program request, 1: erase request, 2: engine idle
    task automatic wait_on(input int k);
        do @(negedge pclk);
        while (!((k == 0 && flash_req === 1'b1) || (k == 1 && flash_erase === 1'b1) ||
            (k == 2 && write_busy === 1'b0)));
    endtask

    task automatic done(input logic f, input logic [3:0] w);
        @(posedge pclk);
        flash_done <= 1'b1;
        flash_fail <= f;
        fail_where <= w;
        @(posedge pclk);
        flash_done <= 1'b0;
        flash_fail <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 22'h000000;
        pwdata = 32'h00000000;
        flash_done = 1'b0;
        flash_fail = 1'b0;
        fail_where = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, t_idx[i], t_wd[i]);
            chk_reg(t_idx[i], t_ex[i]);
        end
        apb(1'b1, FSS_IDX_SECTOR_STATUS_HIGH, 16'h0301);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0020);
        apb(1'b1, FSS_IDX_SECTOR_STATUS_HIGH, 16'h0002);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0002);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0000);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0301);
        // single word, with a staging write refused while busy
        apb(1'b1, FSS_IDX_TARGET_LOC_LOW, 16'h0010);
        apb(1'b1, FSS_IDX_TARGET_LOC_HIGH, 16'h0001);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0003);
        wait_on(0);
        `CHK(flash_addr, 21'h010010)
        `CHK(flash_wdata, 32'h56781234)
        apb(1'b1, FSS_IDX_PROGRAM_DATA0_LOW, 16'h0000);
        done(1'b0, 4'h0);
        wait_on(2);
        chk_reg(FSS_IDX_PROGRAM_DATA0_LOW, 16'h1234);
        // double word
        apb(1'b1, FSS_IDX_TARGET_LOC_LOW, 16'h0020);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0005);
        wait_on(0);
        `CHK(flash_addr, 21'h010020)
        `CHK(flash_wdata, 32'h56781234)
        done(1'b0, 4'h0);
        wait_on(0);
        `CHK(flash_addr, 21'h010024)
        `CHK(flash_wdata, 32'hdef09abc)
        done(1'b0, 4'h0);
        wait_on(2);
        // double word on an odd word is a bad setup; later launches refused until cleared
        apb(1'b1, FSS_IDX_TARGET_LOC_LOW, 16'h0024);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0005);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0041);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0003);
        @(negedge pclk);
        `CHK(write_busy, 1'b0)
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0041);
        apb(1'b1, FSS_IDX_WRITE_ERROR, 16'h0047);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0000);
        // erase on extension array, failing
        apb(1'b1, FSS_IDX_CONTROL, 16'h0011);
        wait_on(1);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0303);
        `CHK(erase_sectors, 4'hf)
        done(1'b1, 4'h5);
        wait_on(2);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0101);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0003);
        apb(1'b1, FSS_IDX_WRITE_ERROR, 16'h0047);
        // erase on primary array, clean
        apb(1'b1, FSS_IDX_CONTROL, 16'h0031);
        wait_on(1);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0303);
        done(1'b0, 4'h0);
        wait_on(2);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0000);
        // erase held, then resumed
        apb(1'b1, FSS_IDX_CONTROL, 16'h0011);
        wait_on(1);
        apb(1'b1, FSS_IDX_CONTROL, 16'h0008);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0303);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0000);
        @(negedge pclk);
        `CHK(write_busy, 1'b1)
        apb(1'b1, FSS_IDX_CONTROL, 16'h0011);
        wait_on(1);
        done(1'b0, 4'h0);
        wait_on(2);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0000);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0000);
        // failing single word program
        apb(1'b1, FSS_IDX_CONTROL, 16'h0003);
        wait_on(0);
        done(1'b1, 4'h0);
        wait_on(2);
        chk_reg(FSS_IDX_WRITE_ERROR, 16'h0005);
        // unmapped places
        apb(1'b0, 20'he0007, 16'h0000);
        `CHK(rerr, 1'b1)
        apb(1'b1, 20'he0018, 16'h0000);
        `CHK(rerr, 1'b1)
        // reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_reg(FSS_IDX_PROGRAM_DATA0_LOW, 16'hffff);
        chk_reg(FSS_IDX_SECTOR_STATUS_HIGH, 16'h0000);
        finish_test();
    end
endmodule // fss_core_bench
